// ---- hw/oag_params.svh ----
`ifndef OAG_PARAMS_SVH
`define OAG_PARAMS_SVH

// Opcodes
`define OAG_OPC_LD_SEC     8'h85
`define OAG_OPC_LD_BDISP   8'hAE
`define OAG_OPC_LD_BIDX_B  8'hAB
`define OAG_OPC_PUSH_SEC   8'hB5
`define OAG_OPC_LD_BASE    8'h87
`define OAG_OPC_LD_BIDX_C  8'hAA

// Register positions within one bank
`define OAG_IDX_C 3'h2
`define OAG_IDX_B 3'h3
`define OAG_IDX_E 3'h4
`define OAG_IDX_D 3'h5
`define OAG_IDX_L 3'h6
`define OAG_IDX_H 3'h7

// Internal high-speed RAM window
`define OAG_HSRAM_LO 16'hFE20
`define OAG_HSRAM_HI 16'hFEFF

// Reset values
`define OAG_ADDR_RST 16'h0000
`define OAG_BYTE_RST 8'h00

`endif

// ---- hw/oag_pkg.sv ----
package oag_pkg;

  typedef enum logic [2:0] {
    OAG_IDLE = 3'b001,
    OAG_DISP = 3'b010,
    OAG_CALC = 3'b100
  } oag_state_e;

  typedef enum logic [2:0] {
    OAG_K_NONE   = 3'h0,
    OAG_K_RI_SEC = 3'h1,
    OAG_K_RI_BSE = 3'h2,
    OAG_K_BASED  = 3'h3,
    OAG_K_BIDX_B = 3'h4,
    OAG_K_BIDX_C = 3'h5,
    OAG_K_STACK  = 3'h6
  } oag_kind_e;

endpackage

// ---- hw/oag_bank_mem.sv ----
`timescale 1ns/1ps

module oag_bank_mem
  import oag_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int BANKS  = 4,
  parameter int REGS   = 8
) (
  input  wire logic                         clk,
  input  wire logic                         wrEn,
  input  wire logic [$clog2(BANKS)-1:0]     wrBank,
  input  wire logic [$clog2(REGS)-1:0]      wrIdx,
  input  wire logic [DATA_W-1:0]            wrData,
  input  wire logic [$clog2(BANKS)-1:0]     rdBank,
  output logic      [REGS*DATA_W-1:0]       rdRegs
);

  localparam int IDX_W = $clog2(REGS);

  logic [DATA_W-1:0] mem [BANKS*REGS];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[{wrBank, wrIdx}] <= wrData;
    end
  end

  // Whole selected bank, registered
  for (genvar gi = 0; gi < REGS; gi++) begin : g_rd
    always_ff @(posedge clk) begin
      rdRegs[gi*DATA_W +: DATA_W] <= mem[{rdBank, IDX_W'(gi)}];
    end
  end

endmodule // oag_bank_mem

// ---- hw/operand_address_generator.sv ----
`timescale 1ns/1ps
`include "oag_params.svh"

// Operation
// - Register-indirect operands use the whole secondary pointer or base pair of the bank.
// - Opcode 85h loads the accumulator from memory addressed by the secondary pointer pair.
// - Based mode adds the 8-bit displacement to the base pair and may reach any address.
// - The displacement is zero-extended to 16 bits and the carry out of bit 15 is dropped.
// - The base pair for based mode comes from the bank the two select flags choose.
// - Opcode AEh with a displacement byte loads the accumulator from the base pair plus it.
// - Based-indexed mode adds zero-extended B or C to the base pair, dropping the carry out.
// - In based-indexed mode the base pair, B and C all come from the selected bank.
// - Opcode ABh loads the accumulator from the base pair plus B.
// - Push, pop, call, return and interrupt save address memory through the stack pointer.
// - Stack addressing outside the internal high-speed RAM window raises stackFault and drops addrValid, but a push still raises pushPair.
// - Opcode B5h pushes the secondary pointer pair onto the stack.
module operand_address_generator
  import oag_pkg::*;
#(
  parameter int          BANKS    = 4,
  parameter int          REGS     = 8,
  parameter logic [15:0] RAM_LO   = `OAG_HSRAM_LO,
  parameter logic [15:0] RAM_HI   = `OAG_HSRAM_HI
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        bankSelectBit0,
  input  wire logic        bankSelectBit1,
  input  wire logic        instrValid,
  input  wire logic [7:0]  instrByte,
  input  wire logic        stackReq,
  input  wire logic        stackPush,
  input  wire logic [15:0] stackPtr,
  input  wire logic        regWrEn,
  input  wire logic [2:0]  regWrIdx,
  input  wire logic [7:0]  regWrData,
  output logic             instrReady,
  output logic             addrValid,
  output logic [15:0]      opAddr,
  output logic [2:0]       addrKind,
  output logic             accLoad,
  output logic             pushPair,
  output logic [15:0]      pushData,
  output logic             stackFault,
  output logic             badOpcode
);

  logic [1:0]      bankSel;
  logic [REGS*8-1:0] bankRegs;
  oag_state_e      state_ff;
  oag_state_e      nxt_state;
  oag_kind_e       kind_ff;
  oag_kind_e       nxt_kind;
  logic [7:0]      disp_ff;
  logic            stkPush_ff;
  logic [15:0]     stkPtr_ff;
  logic [7:0]      regH;
  logic [7:0]      regL;
  logic [7:0]      regD;
  logic [7:0]      regE;
  logic [7:0]      regB;
  logic [7:0]      regC;
  logic [15:0]     basePair;
  logic [15:0]     secondaryPointerPair;
  logic [15:0]     nxt_addr;
  logic [15:0]     stkAddr;
  logic            stkOk;
  logic            takeOp;
  logic            isKnown;

  assign bankSel = {bankSelectBit1, bankSelectBit0};

  oag_bank_mem #(
    .DATA_W (8),
    .BANKS  (BANKS),
    .REGS   (REGS)
  ) u_bank (
    .clk    (clk),
    .wrEn   (regWrEn),
    .wrBank (bankSel),
    .wrIdx  (regWrIdx),
    .wrData (regWrData),
    .rdBank (bankSel),
    .rdRegs (bankRegs)
  );

  // Register fields of the selected bank
  assign regH   = bankRegs[`OAG_IDX_H*8 +: 8];
  assign regL   = bankRegs[`OAG_IDX_L*8 +: 8];
  assign regD   = bankRegs[`OAG_IDX_D*8 +: 8];
  assign regE   = bankRegs[`OAG_IDX_E*8 +: 8];
  assign regB   = bankRegs[`OAG_IDX_B*8 +: 8];
  assign regC   = bankRegs[`OAG_IDX_C*8 +: 8];
  assign basePair             = {regH, regL};
  assign secondaryPointerPair = {regD, regE};

  // Opcode decode
  always_comb begin
    isKnown  = 1'b1;
    nxt_kind = OAG_K_NONE;
    case (instrByte)
      `OAG_OPC_LD_SEC:     nxt_kind = OAG_K_RI_SEC;
      `OAG_OPC_LD_BASE:    nxt_kind = OAG_K_RI_BSE;
      `OAG_OPC_LD_BDISP:   nxt_kind = OAG_K_BASED;
      `OAG_OPC_LD_BIDX_B:  nxt_kind = OAG_K_BIDX_B;
      `OAG_OPC_LD_BIDX_C:  nxt_kind = OAG_K_BIDX_C;
      `OAG_OPC_PUSH_SEC:   nxt_kind = OAG_K_STACK;
      default:             isKnown  = 1'b0;
    endcase
  end

  assign takeOp = (state_ff == OAG_IDLE) && instrValid && isKnown;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      OAG_IDLE: begin
        if (takeOp && nxt_kind == OAG_K_BASED) begin
          nxt_state = OAG_DISP;
        end else if (takeOp || stackReq) begin
          nxt_state = OAG_CALC;
        end
      end
      OAG_DISP: begin
        if (instrValid) begin
          nxt_state = OAG_CALC;
        end
      end
      OAG_CALC: nxt_state = OAG_IDLE;
      default:  nxt_state = OAG_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= OAG_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Captured operation
  always_ff @(posedge clk) begin
    if (srst) begin
      kind_ff    <= OAG_K_NONE;
      stkPush_ff <= 1'b0;
      stkPtr_ff  <= `OAG_ADDR_RST;
    end else if (state_ff == OAG_IDLE) begin
      if (takeOp) begin
        kind_ff    <= nxt_kind;
        stkPush_ff <= (nxt_kind == OAG_K_STACK);
        stkPtr_ff  <= stackPtr;
      end else if (stackReq) begin
        kind_ff    <= OAG_K_STACK;
        stkPush_ff <= stackPush;
        stkPtr_ff  <= stackPtr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      disp_ff <= `OAG_BYTE_RST;
    end else if (state_ff == OAG_DISP && instrValid) begin
      disp_ff <= instrByte;
    end
  end

  // Push writes below the pointer, pop reads at it
  assign stkAddr = stkPush_ff ? 16'(stkPtr_ff - 16'h0001) : stkPtr_ff;
  assign stkOk   = (stkAddr >= RAM_LO) && (stkAddr <= RAM_HI);

  always_comb begin
    nxt_addr = `OAG_ADDR_RST;
    case (kind_ff)
      OAG_K_RI_SEC: nxt_addr = secondaryPointerPair;
      OAG_K_RI_BSE: nxt_addr = basePair;
      OAG_K_BASED:  nxt_addr = 16'(basePair + {8'h00, disp_ff});
      OAG_K_BIDX_B: nxt_addr = 16'(basePair + {8'h00, regB});
      OAG_K_BIDX_C: nxt_addr = 16'(basePair + {8'h00, regC});
      OAG_K_STACK:  nxt_addr = stkAddr;
      default:      nxt_addr = `OAG_ADDR_RST;
    endcase
  end

  // Address result
  always_ff @(posedge clk) begin
    if (srst) begin
      addrValid  <= 1'b0;
      opAddr     <= `OAG_ADDR_RST;
      addrKind   <= OAG_K_NONE;
      accLoad    <= 1'b0;
      pushPair   <= 1'b0;
      pushData   <= `OAG_ADDR_RST;
      stackFault <= 1'b0;
    end else if (state_ff == OAG_CALC) begin
      addrValid  <= (kind_ff != OAG_K_STACK) || stkOk;
      opAddr     <= nxt_addr;
      addrKind   <= kind_ff;
      accLoad    <= (kind_ff != OAG_K_STACK);
      pushPair   <= (kind_ff == OAG_K_STACK) && stkPush_ff;
      pushData   <= secondaryPointerPair;
      stackFault <= (kind_ff == OAG_K_STACK) && !stkOk;
    end else begin
      addrValid  <= 1'b0;
      pushPair   <= 1'b0;
      stackFault <= 1'b0;
    end
  end

  // Handshake and decode error
  always_ff @(posedge clk) begin
    if (srst) begin
      instrReady <= 1'b0;
      badOpcode  <= 1'b0;
    end else begin
      instrReady <= (nxt_state != OAG_CALC);
      badOpcode  <= (state_ff == OAG_IDLE) && instrValid && !isKnown;
    end
  end

endmodule // operand_address_generator

// ---- bench/oag_chk.sv ----
`timescale 1ns/1ps
module oag_chk (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        instrValid,
  input wire logic        instrReady,
  input wire logic [7:0]  instrByte,
  input wire logic        stackReq,
  input wire logic        stackPush,
  input wire logic [15:0] stackPtr,
  input wire logic        addrValid,
  input wire logic [15:0] opAddr,
  input wire logic [2:0]  addrKind,
  input wire logic        accLoad,
  input wire logic        pushPair,
  input wire logic        stackFault
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence stackTake;
    stackReq && !instrValid && instrReady;
  endsequence
  de_load_a: assert property (addrValid && addrKind == 3'h1 |-> accLoad)
    else $error("pointer load without accumulator flag");
  hlb_opcode_a: assert property (addrValid && addrKind == 3'h4 |-> $past(instrByte, 2) == 8'hAB)
    else $error("indexed result without its opcode");
  based_load_a: assert property (addrValid && addrKind == 3'h3 |-> accLoad)
    else $error("based load without accumulator flag");
  push_addr_a: assert property (addrValid && pushPair |-> opAddr == $past(stackPtr, 2) - 16'h1)
    else $error("push address not one below pointer");
  pop_addr_a: assert property (addrValid && addrKind == 3'h6 && !pushPair |-> opAddr == $past(stackPtr, 2))
    else $error("pop address not the pointer");
  stack_win_a: assert property (addrValid && addrKind == 3'h6 |-> opAddr >= 16'hFE20 && opAddr <= 16'hFEFF)
    else $error("stack address outside fast RAM");
  fault_excl_a: assert property (stackFault |-> !addrValid)
    else $error("fault together with valid address");
  stack_resp_a: assert property (stackTake |-> ##2 (addrValid ^ stackFault) && pushPair == $past(stackPush, 2))
    else $error("stack request not answered in two cycles");
endmodule // oag_chk

bind operand_address_generator oag_chk i_oag_chk (.*);

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  import oag_pkg::*;
  logic        clk, srst, bankSelectBit0, bankSelectBit1, instrValid, stackReq, stackPush;
  logic        regWrEn, instrReady, addrValid, accLoad, pushPair, stackFault, badOpcode;
  logic [7:0]  instrByte, regWrData;
  logic [15:0] stackPtr, opAddr, pushData;
  logic [2:0]  regWrIdx, addrKind;
  logic [7:0]  sh [4][8];
  int          errTotal, totalChecks;
  operand_address_generator i_operand_address_generator (.*);
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task stopTest;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task step;
    @(posedge clk);
    #1;
  endtask
  task sel(input int b);
    {bankSelectBit1, bankSelectBit0} = 2'(b);
    step;
    step;
  endtask
  task wr(input int b, input logic [2:0] i, input logic [7:0] d);
    regWrEn = 1;
    regWrIdx = i;
    regWrData = d;
    sh[b][i] = d;
    step;
    regWrEn = 0;
    step;
  endtask
  task run(input logic [7:0] opc, input logic [7:0] d, input logic sreq,
           input logic [15:0] ea, input logic [2:0] k, input logic flt);
    int n;
    instrValid = !sreq;
    instrByte = opc;
    stackReq = sreq;
    step;
    stackReq = 0;
    instrByte = d;
    cmp(instrReady, opc == 8'hAE && !sreq);
    if (opc == 8'hAE) step;
    instrValid = 0;
    n = 0;
    while (addrValid !== 1'b1 && stackFault !== 1'b1 && n < 4) begin
      step;
      n++;
    end
    if (addrValid !== 1'b1 && stackFault !== 1'b1) begin
      errTotal++;
      stopTest;
    end
    cmp(stackFault, flt);
    cmp(accLoad, k != 3'h6);
    if (!flt) begin
      cmp(opAddr, ea);
      cmp(addrKind, k);
    end
  endtask
  task tBanks;
    logic [15:0] bp;
    for (int b = 0; b < 4; b++) begin
      sel(b);
      wr(b, 3'h7, 8'hFF - 8'(b * 64));
      wr(b, 3'h6, 8'hF0 + 8'(b));
      wr(b, 3'h5, 8'(b + 1));
      wr(b, 3'h4, 8'h05 + 8'(b * 16));
      wr(b, 3'h3, 8'h20 + 8'(b));
      wr(b, 3'h2, 8'hC0 + 8'(b));
    end
    for (int b = 0; b < 4; b++) begin
      sel(b);
      bp = {sh[b][7], sh[b][6]};
      run(8'h85, 8'h00, 0, {sh[b][5], sh[b][4]}, 3'h1, 0);
      run(8'h87, 8'h00, 0, bp, 3'h2, 0);
      run(8'hAE, 8'hFF, 0, bp + 16'h00FF, 3'h3, 0);
      run(8'hAB, 8'h00, 0, bp + {8'h00, sh[b][3]}, 3'h4, 0);
      run(8'hAA, 8'h00, 0, bp + {8'h00, sh[b][2]}, 3'h5, 0);
    end
    $display("tBanks done");
  endtask
  task tStack;
    sel(0);
    stackPtr = 16'hFE21;
    run(8'hB5, 8'h00, 0, 16'hFE20, 3'h6, 0);
    cmp(pushPair, 1);
    cmp(pushData, {sh[0][5], sh[0][4]});
    stackPush = 0;
    stackPtr = 16'hFEFF;
    run(8'h00, 8'h00, 1, 16'hFEFF, 3'h6, 0);
    cmp(pushPair, 0);
    stackPush = 1;
    stackPtr = 16'hFF00;
    run(8'h00, 8'h00, 1, 16'hFEFF, 3'h6, 0);
    stackPtr = 16'hFE20;
    run(8'h00, 8'h00, 1, 16'h0000, 3'h6, 1);
    stackPush = 0;
    stackPtr = 16'hFF00;
    run(8'h00, 8'h00, 1, 16'h0000, 3'h6, 1);
    $display("tStack done");
  endtask
  task tBad;
    instrValid = 1;
    instrByte = 8'h00;
    step;
    instrValid = 0;
    cmp(badOpcode, 1);
    cmp(instrReady, 1);
    step;
    cmp(badOpcode, 0);
    cmp(addrValid, 0);
    $display("tBad done");
  endtask
  initial begin
    srst = 1;
    {bankSelectBit1, bankSelectBit0, instrValid, stackReq, stackPush, regWrEn} = '0;
    {instrByte, regWrData, regWrIdx, stackPtr} = '0;
    repeat (20) @(posedge clk);
    #1;
    srst = 0;
    tBanks;
    tStack;
    tBad;
    stopTest;
  end
endmodule // tb
